// File: src/pm_status_shadow_registers.sv
// Power-management NMI status, port mirror, interrupt-controller snapshot and rtc_index_and_timing_mirror registers
`include "pm_shadow_cfg.svh"

// Contract
// - Set cause flag 7-2 for each input that raised NMI.
// - A cause flag clears only when software clears its enables.
// - With attention and NMI enables both set, both must clear.
// - Status bits 15-8 and 1-0 read zero.
// - Mirror 15-14 copy serial A register 2 bits 7-6.
// - Mirror 13-12 copy serial B register 2 bits 7-6.
// - Mirror 11-8 copy parallel register 2 bits 3-0.
// - Mirror 7-0 copy parallel register 0.
// - Snapshot bit 15 is the live idle comparator.
// - Snapshot 14-13 hold the device identification field.
// - Bits 12 and 11 hold master and slave vector bit 7.
// - Bit 10 is the master nested-mode bit.
// - Bit 9 is the master automatic end-of-interrupt bit.
// - Bit 8 is one when master rotate-on-auto-EOI is selected.
// - Bits 7-5 hold master bottom priority.
// - Bit 1 is master special mask mode.
// - Bit 0 is slave special mask mode.
// - Timing word reads without the unlock sequence.
// - Timing bits 7-0 hold the last clock index write.
// - Bit 15 is the refresh reference halved.
// - Bit 14 toggles on every refresh.
// - Bit 13 is the live processor interrupt request.
// - Bit 12 low after recent DMA, high after a quiet period.
module pm_status_shadow_registers
    import pm_shadow_pkg::*;
#(
    parameter int         DMA_IDLE_CYCLES = `DMA_IDLE_CYCLES,
    parameter logic [1:0] DEVICE_ID       = 2'h1  // Arbitrary value
) (
    // Clock, reset, enable
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            ce,
    // I/O port access
    input  wire logic [15:0]     io_addr,
    input  wire logic            io_wr,
    input  wire logic            io_rd,
    input  wire logic [15:0]     io_wdata,
    output logic      [15:0]     io_rdata,
    output logic                 io_rvalid,
    input  wire logic            regs_unlocked,
    // Power-management input events and enables
    input  wire logic [7:2]      nmi_event,
    input  wire logic [7:2]      nmi_source_enable,
    input  wire logic [7:2]      attention_source_enable,
    output logic      [7:2]      nmi_cause_flag,
    // Mirrored port registers
    input  wire port_mirror_type port_regs,
    // Interrupt controller writes and status
    input  wire pic_write_type   master_pic,
    input  wire pic_write_type   slave_pic,
    input  wire logic            idle_comparator_state,
    input  wire logic            cpu_interrupt_request,
    // Timing sources
    input  wire logic            standby_refresh_reference,
    input  wire logic            refresh_done,
    input  wire logic            dma_cycle
);
    initial begin
        if (DMA_IDLE_CYCLES < 1) begin
            $error("DMA_IDLE_CYCLES below 1");
        end
    end

    // Decode an I/O address into a one-hot register select
    function automatic reg_sel_type decode(input logic [15:0] addr);
        case (addr)
            `NMI_CAUSE_FLAGS_ADDR:         decode = SEL_NMI;
            `SERIAL_PARALLEL_MIRROR_ADDR:  decode = SEL_SERPAR;
            `IRQ_CONTROLLER_SNAPSHOT_ADDR: decode = SEL_PIC;
            `RTC_INDEX_TIMING_MIRROR_ADDR: decode = SEL_P70;
            default:                       decode = SEL_NONE;
        endcase
    endfunction : decode

    // Only the rtc_index_and_timing_mirror is open while the register file is locked
    function automatic logic needs_unlock(input reg_sel_type sel);
        needs_unlock = (sel != SEL_P70) && (sel != SEL_NONE);
    endfunction : needs_unlock

    // Internal state
    logic [7:2] cause_reg;
    logic       master_vector_msb;
    logic       slave_vector_msb;
    logic       special_nested_flag;
    logic       auto_eoi_flag;
    logic       rotate_auto_eoi_flag;
    logic [2:0] master_bottom_priority;
    logic [2:0] slave_bottom_priority;
    logic       master_special_mask;
    logic       slave_special_mask;
    logic [7:0] clock_ram_index;
    logic       slow_timing_square_wave;
    logic       refresh_toggle;
    logic       reference_sync;
    logic       reference_last;
    logic       dma_idle_indicator;

    reg_sel_type rd_sel;
    logic [15:0] nmi_word;
    logic [15:0] serpar_word;
    logic [15:0] pic_word;
    logic [15:0] p70_word;
    logic [15:0] rdata_next;

    assign nmi_cause_flag = cause_reg;

    // Cause flags: set needs the NMI enable, clear needs both enables low, so the two never collide
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cause_reg <= '0;
        end else if (ce) begin
            for (int i = `CAUSE_LO; i <= `CAUSE_HI; i++) begin
                if (nmi_event[i] && nmi_source_enable[i]) begin
                    cause_reg[i] <= 1'b1;
                end else if (!nmi_source_enable[i] && !attention_source_enable[i]) begin
                    cause_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Vector bit 7 from each controller's ICW2
    always_ff @(posedge clk) begin
        if (!rstn) begin
            master_vector_msb <= 1'b0;
            slave_vector_msb  <= 1'b0;
        end else if (ce) begin
            if (master_pic.icw2_wr) begin
                master_vector_msb <= master_pic.data[7];
            end
            if (slave_pic.icw2_wr) begin
                slave_vector_msb <= slave_pic.data[7];
            end
        end
    end

    // ICW4 mode bits, master only; the slave's copies are of no use here
    always_ff @(posedge clk) begin
        if (!rstn) begin
            special_nested_flag <= 1'b0;
            auto_eoi_flag       <= 1'b0;
        end else if (ce && master_pic.icw4_wr) begin
            special_nested_flag <= master_pic.data[`ICW4_SPECIAL_NESTED_FLAG_BIT];
            auto_eoi_flag       <= master_pic.data[`ICW4_AEOI_BIT];
        end
    end

    // Rotate-on-automatic-EOI follows the master's set and clear OCW2 commands
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rotate_auto_eoi_flag <= 1'b0;
        end else if (ce && master_pic.ocw2_wr) begin
            if (master_pic.data[7:5] == `OCW2_ROTATE_AEOI_SET) begin
                rotate_auto_eoi_flag <= 1'b1;
            end else if (master_pic.data[7:5] == `OCW2_ROTATE_AEOI_CLEAR) begin
                rotate_auto_eoi_flag <= 1'b0;
            end
        end
    end

    // Bottom priority: taken from OCW2 level bits only on commands that select a level
    always_ff @(posedge clk) begin
        if (!rstn) begin
            master_bottom_priority <= `PRIORITY_RESET;
            slave_bottom_priority  <= `PRIORITY_RESET;
        end else if (ce) begin
            if (master_pic.ocw2_wr && master_pic.data[7] && master_pic.data[6]) begin
                master_bottom_priority <= master_pic.data[2:0];
            end
            if (slave_pic.ocw2_wr && slave_pic.data[7] && slave_pic.data[6]) begin
                slave_bottom_priority <= slave_pic.data[2:0];
            end
        end
    end

    // Special mask mode changes only when OCW3 carries its enable bit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            master_special_mask <= 1'b0;
            slave_special_mask  <= 1'b0;
        end else if (ce) begin
            if (master_pic.ocw3_wr) begin
                if (master_pic.data[6:5] == `OCW3_SMM_SET) begin
                    master_special_mask <= 1'b1;
                end else if (master_pic.data[6:5] == `OCW3_SMM_CLEAR) begin
                    master_special_mask <= 1'b0;
                end
            end
            if (slave_pic.ocw3_wr) begin
                if (slave_pic.data[6:5] == `OCW3_SMM_SET) begin
                    slave_special_mask <= 1'b1;
                end else if (slave_pic.data[6:5] == `OCW3_SMM_CLEAR) begin
                    slave_special_mask <= 1'b0;
                end
            end
        end
    end

    // Clock index port capture; NMI disable set after reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            clock_ram_index <= `RTC_INDEX_RESET;
        end else if (ce && io_wr && (io_addr == `RTC_INDEX_PORT_ADDR)) begin
            clock_ram_index <= io_wdata[7:0];
        end
    end

    // Refresh reference comes from a pin, so it is synchronised first
    pin_sync #(
        .WIDTH    (1)
    ) u_reference_sync (
        .clk      (clk),
        .rstn     (rstn),
        .ce       (ce),
        .async_in (standby_refresh_reference),
        .sync_out (reference_sync)
    );

    // Halve the reference on its rising edges; refresh-rate settings never touch it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reference_last          <= 1'b0;
            slow_timing_square_wave <= 1'b0;
        end else if (ce) begin
            reference_last <= reference_sync;
            if (reference_sync && !reference_last) begin
                slow_timing_square_wave <= !slow_timing_square_wave;
            end
        end
    end

    // Refresh toggle flips once per refresh
    always_ff @(posedge clk) begin
        if (!rstn) begin
            refresh_toggle <= 1'b0;
        end else if (ce && refresh_done) begin
            refresh_toggle <= !refresh_toggle;
        end
    end

    // DMA quiet-period tracking
    dma_idle_timer #(
        .IDLE_CYCLES (DMA_IDLE_CYCLES)
    ) u_dma_idle (
        .clk         (clk),
        .rstn        (rstn),
        .ce          (ce),
        .dma_cycle   (dma_cycle),
        .dma_idle    (dma_idle_indicator)
    );

    // NMI status word: unused bits forced to zero
    always_comb begin
        nmi_word                       = '0;
        nmi_word[`CAUSE_HI:`CAUSE_LO]  = cause_reg;
    end

    // Port mirror word, live copies of the port registers
    always_comb begin
        serpar_word        = '0;
        serpar_word[15:14] = port_regs.serial_a_reg2[7:6];
        serpar_word[13:12] = port_regs.serial_b_reg2[7:6];
        serpar_word[11:8]  = port_regs.parallel_reg2[3:0];
        serpar_word[7:0]   = port_regs.parallel_reg0;
    end

    // Interrupt-controller snapshot word
    always_comb begin
        pic_word        = '0;
        pic_word[15]    = idle_comparator_state;
        pic_word[14:13] = DEVICE_ID;
        pic_word[12]    = master_vector_msb;
        pic_word[11]    = slave_vector_msb;
        pic_word[10]    = special_nested_flag;
        pic_word[9]     = auto_eoi_flag;
        pic_word[8]     = rotate_auto_eoi_flag;
        pic_word[7:5]   = master_bottom_priority;
        pic_word[4:2]   = slave_bottom_priority;
        pic_word[1]     = master_special_mask;
        pic_word[0]     = slave_special_mask;
    end

    // Rtc_index_and_timing_mirror word; bits 11-8 read zero
    always_comb begin
        p70_word                    = '0;
        p70_word[`P70_SQUARE_BIT]   = slow_timing_square_wave;
        p70_word[`P70_REFRESH_BIT]  = refresh_toggle;
        p70_word[`P70_CPU_INTERRUPT_REQUEST_BIT]    = cpu_interrupt_request;
        p70_word[`P70_DMA_IDLE_BIT] = dma_idle_indicator;
        p70_word[7:0]               = clock_ram_index;
    end

    // Read mux; locked protected and unmapped reads give zero
    always_comb begin
        rd_sel     = decode(io_addr);
        rdata_next = 16'h0000;
        if (!(needs_unlock(rd_sel) && !regs_unlocked)) begin
            case (rd_sel)
                SEL_NMI:    rdata_next = nmi_word;
                SEL_SERPAR: rdata_next = serpar_word;
                SEL_PIC:    rdata_next = pic_word;
                SEL_P70:    rdata_next = p70_word;
                default:    rdata_next = 16'h0000;
            endcase
        end
    end

    // Read data held in a register until the next read
    always_ff @(posedge clk) begin
        if (!rstn) begin
            io_rdata  <= 16'h0000;
            io_rvalid <= 1'b0;
        end else if (ce) begin
            io_rvalid <= io_rd;
            if (io_rd) begin
                io_rdata <= rdata_next;
            end
        end
    end
endmodule : pm_status_shadow_registers

// File: src/pm_shadow_cfg.svh
// Offsets, field positions, reset values and timing for the power-management shadow registers
`ifndef PM_SHADOW_CFG_SVH
`define PM_SHADOW_CFG_SVH

// I/O port addresses
`define NMI_CAUSE_FLAGS_ADDR        16'h9072
`define SERIAL_PARALLEL_MIRROR_ADDR 16'hD072
`define IRQ_CONTROLLER_SNAPSHOT_ADDR 16'hD472
`define RTC_INDEX_TIMING_MIRROR_ADDR 16'hE472
`define RTC_INDEX_PORT_ADDR         16'h0070

// Register width and cause-flag span
`define REG_WIDTH                   16
`define CAUSE_LO                    2
`define CAUSE_HI                    7

// Rtc_index_and_timing_mirror field positions
`define P70_SQUARE_BIT              15
`define P70_REFRESH_BIT             14
`define P70_CPU_INTERRUPT_REQUEST_BIT               13
`define P70_DMA_IDLE_BIT            12

// Reset values
`define RTC_INDEX_RESET             8'h80
`define PRIORITY_RESET              3'h7

// Interrupt-controller command field codes
`define OCW2_ROTATE_AEOI_SET        3'h4
`define OCW2_ROTATE_AEOI_CLEAR      3'h0
`define OCW3_SMM_SET                2'h3
`define OCW3_SMM_CLEAR              2'h2
`define ICW4_SPECIAL_NESTED_FLAG_BIT               4
`define ICW4_AEOI_BIT               1

// Timing
`define CLK_PERIOD_PS               4000
`define DMA_IDLE_PS                 30500000
`define DMA_IDLE_CYCLES             ((`DMA_IDLE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// File: src/pm_shadow_pkg.sv
// Types shared by the power-management shadow register bank
package pm_shadow_pkg;

    // One interrupt controller's register writes, seen as strobes with a data byte
    typedef struct packed {
        logic       icw2_wr;
        logic       icw4_wr;
        logic       ocw2_wr;
        logic       ocw3_wr;
        logic [7:0] data;
    } pic_write_type;

    // Serial and parallel port register contents that are mirrored
    typedef struct packed {
        logic [7:0] serial_a_reg2;
        logic [7:0] serial_b_reg2;
        logic [7:0] parallel_reg2;
        logic [7:0] parallel_reg0;
    } port_mirror_type;

    // One-hot register selection
    typedef enum logic [4:0] {
        SEL_NONE   = 5'b00001,
        SEL_NMI    = 5'b00010,
        SEL_SERPAR = 5'b00100,
        SEL_PIC    = 5'b01000,
        SEL_P70    = 5'b10000
    } reg_sel_type;

endpackage : pm_shadow_pkg

// File: src/pin_sync.sv
// Two-flop synchroniser for pin inputs, one lane per bit
module pin_sync
    import pm_shadow_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // Asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    initial begin
        if (WIDTH < 1) begin
            $error("WIDTH below 1");
        end
    end

    genvar lane;
    generate
        for (lane = 0; lane < WIDTH; lane++) begin : g_lane
            logic meta_reg;
            // First flop feeds only the second flop
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    meta_reg            <= 1'b0;
                    sync_out[lane]      <= 1'b0;
                end else if (ce) begin
                    meta_reg            <= async_in[lane];
                    sync_out[lane]      <= meta_reg;
                end
            end
        end
    endgenerate
endmodule : pin_sync

// File: src/dma_idle_timer.sv
// Quiet-time timer that reports when no DMA or bus master cycle has been seen lately
module dma_idle_timer
    import pm_shadow_pkg::*;
#(
    parameter int IDLE_CYCLES = 7625
) (
    // Clock, reset, enable
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    // Activity pulse in, idle level out
    input  wire logic dma_cycle,
    output logic      dma_idle
);
    localparam int CW = $clog2(IDLE_CYCLES + 1);

    initial begin
        if (IDLE_CYCLES < 1) begin
            $error("IDLE_CYCLES below 1");
        end
    end

    logic [CW-1:0] quiet_reg;

    // Count quiet cycles, restart on any DMA cycle; saturates at the limit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            quiet_reg <= '0;
        end else if (ce) begin
            if (dma_cycle) begin
                quiet_reg <= '0;
            end else if (quiet_reg != CW'(IDLE_CYCLES)) begin
                quiet_reg <= quiet_reg + CW'(1);
            end
        end
    end

    // Idle goes low the cycle after activity, high once a full quiet period passed
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dma_idle <= 1'b0;
        end else if (ce) begin
            dma_idle <= !dma_cycle && (quiet_reg == CW'(IDLE_CYCLES));
        end
    end
endmodule : dma_idle_timer

// File: dv/pm_status_shadow_registers_checker.sv
// Assertion checker for the power-management shadow register bank
`include "pm_shadow_cfg.svh"
module pm_status_shadow_registers_checker
    import pm_shadow_pkg::*;
#(
    parameter logic [1:0] DEVICE_ID = 2'h1
) (
    // Clock, reset, enable
    input wire logic            clk,
    input wire logic            rstn,
    input wire logic            ce,
    // I/O port access
    input wire logic [15:0]     io_addr,
    input wire logic            io_wr,
    input wire logic            io_rd,
    input wire logic [15:0]     io_wdata,
    input wire logic [15:0]     io_rdata,
    input wire logic            io_rvalid,
    input wire logic            regs_unlocked,
    // Cause flags and their enables
    input wire logic [7:2]      nmi_event,
    input wire logic [7:2]      nmi_source_enable,
    input wire logic [7:2]      attention_source_enable,
    input wire logic [7:2]      nmi_cause_flag,
    // Mirrored and live sources
    input wire port_mirror_type port_regs,
    input wire logic            idle_comparator_state,
    input wire logic            cpu_interrupt_request
);
    logic [15:0]     addr_reg;
    logic            unlocked_reg;
    logic [7:2]      set_reg;
    logic [7:2]      clr_reg;
    logic [7:0]      index_reg;
    port_mirror_type mirror_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Address and lock state of the read in flight, judged when its answer lands
    always_ff @(posedge clk) begin
        if (ce && io_rd) begin
            addr_reg     <= io_addr;
            unlocked_reg <= regs_unlocked;
        end
    end

    // Flags owed a set or clear; reset counts as a clear
    always_ff @(posedge clk) begin
        set_reg <= (rstn && ce) ? (nmi_event & nmi_source_enable) : 6'h00;
        clr_reg <= !rstn ? 6'h3f : (ce ? ~(nmi_source_enable | attention_source_enable) : 6'h00);
    end

    // Clock index port model; reset leaves NMI disabled
    always_ff @(posedge clk) begin
        if (!rstn) begin
            index_reg <= 8'h80;
        end else if (ce && io_wr && io_addr == `RTC_INDEX_PORT_ADDR) begin
            index_reg <= io_wdata[7:0];
        end
    end

    // Port contents as they stood at the read edge
    always_ff @(posedge clk) begin
        mirror_reg <= port_regs;
    end

    property p_read_answer;
        ce && io_rd |=> io_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_cause_set;
        (nmi_cause_flag & set_reg) == set_reg;
    endproperty
    a_cause_set: assert property (p_cause_set) else $error("cause flag not set");
    property p_cause_clear;
        (nmi_cause_flag & clr_reg) == 6'h00;
    endproperty
    a_cause_clear: assert property (p_cause_clear) else $error("cause flag not cleared");
    property p_cause_hold;
        ($past(nmi_cause_flag) & ~nmi_cause_flag & ~clr_reg) == 6'h00;
    endproperty
    a_cause_hold: assert property (p_cause_hold) else $error("cause flag dropped early");
    property p_nmi_read;
        io_rvalid && unlocked_reg && addr_reg == `NMI_CAUSE_FLAGS_ADDR
            |-> io_rdata == {8'h00, $past(nmi_cause_flag), 2'h0};
    endproperty
    a_nmi_read: assert property (p_nmi_read) else $error("bad status word");
    property p_mirror_read;
        io_rvalid && unlocked_reg && addr_reg == `SERIAL_PARALLEL_MIRROR_ADDR
            |-> io_rdata == {mirror_reg.serial_a_reg2[7:6], mirror_reg.serial_b_reg2[7:6],
                             mirror_reg.parallel_reg2[3:0], mirror_reg.parallel_reg0};
    endproperty
    a_mirror_read: assert property (p_mirror_read) else $error("bad mirror word");
    property p_snap_live;
        io_rvalid && unlocked_reg && addr_reg == `IRQ_CONTROLLER_SNAPSHOT_ADDR
            |-> io_rdata[15:13] == {$past(idle_comparator_state), DEVICE_ID};
    endproperty
    a_snap_live: assert property (p_snap_live) else $error("bad snapshot top bits");
    property p_index_read;
        io_rvalid && addr_reg == `RTC_INDEX_TIMING_MIRROR_ADDR
            |-> io_rdata[13] == $past(cpu_interrupt_request) && io_rdata[11:0] == {4'h0, $past(index_reg)};
    endproperty
    a_index_read: assert property (p_index_read) else $error("bad timing word");
    property p_locked_read;
        io_rvalid && !unlocked_reg && addr_reg != `RTC_INDEX_TIMING_MIRROR_ADDR |-> io_rdata == 16'h0000;
    endproperty
    a_locked_read: assert property (p_locked_read) else $error("locked read leaked");

    c_cause_set: cover property (|set_reg);
    c_locked_read: cover property (io_rvalid && !unlocked_reg);
    c_index_read: cover property (io_rvalid && addr_reg == `RTC_INDEX_TIMING_MIRROR_ADDR);
endmodule : pm_status_shadow_registers_checker

// File: dv/pm_status_shadow_registers_test.sv
// Self-checking bench for the power-management shadow register bank
`include "pm_shadow_cfg.svh"
module pm_status_shadow_registers_test
    import pm_shadow_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int          IDLE_CYCLES = 20;
    localparam logic [15:0] nmi_a = `NMI_CAUSE_FLAGS_ADDR;
    localparam logic [15:0] spm_a = `SERIAL_PARALLEL_MIRROR_ADDR;
    localparam logic [15:0] pic_a = `IRQ_CONTROLLER_SNAPSHOT_ADDR;
    localparam logic [15:0] tim_a = `RTC_INDEX_TIMING_MIRROR_ADDR;

    logic            clk;
    logic            rstn;
    logic            ce;
    logic [15:0]     io_addr;
    logic            io_wr;
    logic            io_rd;
    logic [15:0]     io_wdata;
    logic [15:0]     io_rdata;
    logic            io_rvalid;
    logic            regs_unlocked;
    logic [7:2]      nmi_event;
    logic [7:2]      nmi_source_enable;
    logic [7:2]      attention_source_enable;
    logic [7:2]      nmi_cause_flag;
    port_mirror_type port_regs;
    pic_write_type   master_pic;
    pic_write_type   slave_pic;
    logic            idle_comparator_state;
    logic            cpu_interrupt_request;
    logic            standby_refresh_reference;
    logic            refresh_done;
    logic            dma_cycle;
    int              num_errors;
    int              total_checks;

    pm_status_shadow_registers #(
        .DMA_IDLE_CYCLES(IDLE_CYCLES)
    ) pm_status_shadow_registers_i (
        .*
    );

    // Free-running 250 MHz clock
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // One read; answer registered on the edge that takes it, checked 1 ns later
    task automatic rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'h1;
        @(posedge clk);
        io_rd <= 1'h0;
        #1;
        chk({15'h0000, io_rvalid}, 16'h0001);
        chk(io_rdata & m, e);
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'h1;
        @(posedge clk);
        io_wr <= 1'h0;
    endtask : wr

    // Controller command write; kind picks ICW2, ICW4, OCW2 or OCW3
    task automatic pic(input logic is_slave, input logic [1:0] kind, input logic [7:0] d);
        pic_write_type p;
        p = {kind == 2'h0, kind == 2'h1, kind == 2'h2, kind == 2'h3, d};
        @(posedge clk);
        if (is_slave) begin
            slave_pic <= p;
        end else begin
            master_pic <= p;
        end
        @(posedge clk);
        master_pic <= '0;
        slave_pic  <= '0;
    endtask : pic

    task automatic stop_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // Watchdog far past the sequence length
    initial begin
        #20000;
        num_errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        {rstn, io_wr, io_rd, regs_unlocked, idle_comparator_state} = 5'h00;
        {cpu_interrupt_request, standby_refresh_reference, refresh_done, dma_cycle} = 4'h0;
        ce = 1'h1;
        {io_addr, io_wdata} = 32'h0000_0000;
        {nmi_event, nmi_source_enable, attention_source_enable} = 18'h0_0000;
        port_regs = 32'h0000_0000;
        master_pic = '0;
        slave_pic = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'h1;
        repeat (30) @(posedge clk);
        // Locked: only the timing word answers
        rd(tim_a, 16'hffff, 16'h1080);
        rd(nmi_a, 16'hffff, 16'h0000);
        rd(spm_a, 16'hffff, 16'h0000);
        rd(pic_a, 16'hffff, 16'h0000);
        regs_unlocked <= 1'h1;
        rd(16'h1234, 16'hffff, 16'h0000);
        wr(16'h0070, 16'hff3a);
        cpu_interrupt_request <= 1'h1;
        rd(tim_a, 16'hffff, 16'h303a);
        port_regs <= 32'hc581_3ca7;
        rd(spm_a, 16'hffff, 16'heca7);
        port_regs <= 32'h407f_f35a;
        rd(spm_a, 16'hffff, 16'h535a);
        // Cause flags: 4 not enabled, 3 has both enables
        nmi_source_enable <= 6'h12;
        attention_source_enable <= 6'h02;
        @(posedge clk);
        nmi_event <= 6'h16;
        @(posedge clk);
        nmi_event <= 6'h00;
        #1;
        chk({10'h000, nmi_cause_flag}, 16'h0012);
        wr(nmi_a, 16'hffff);
        rd(nmi_a, 16'hffff, 16'h0048);
        nmi_source_enable <= 6'h10;
        rd(nmi_a, 16'hffff, 16'h0048);
        attention_source_enable <= 6'h00;
        rd(nmi_a, 16'hffff, 16'h0040);
        nmi_source_enable <= 6'h00;
        rd(nmi_a, 16'hffff, 16'h0000);
        // Snapshot: reset values, then set each field and clear all but idle, slave vector bit 7 and the bottom priorities
        rd(pic_a, 16'hffff, 16'h20fc);
        idle_comparator_state <= 1'h1;
        pic(1'h0, 2'h0, 8'h80);
        pic(1'h1, 2'h0, 8'h80);
        pic(1'h0, 2'h1, 8'h12);
        pic(1'h0, 2'h2, 8'h80);
        pic(1'h0, 2'h2, 8'hc2);
        pic(1'h1, 2'h2, 8'he5);
        pic(1'h0, 2'h3, 8'h60);
        pic(1'h1, 2'h3, 8'h60);
        rd(pic_a, 16'hffff, 16'hbf57);
        pic(1'h0, 2'h2, 8'h00);
        pic(1'h1, 2'h2, 8'h80);
        pic(1'h0, 2'h3, 8'h40);
        pic(1'h1, 2'h3, 8'h40);
        pic(1'h0, 2'h0, 8'h00);
        pic(1'h0, 2'h1, 8'h00);
        pic(1'h1, 2'h1, 8'h12);
        rd(pic_a, 16'hffff, 16'ha854);
        // Refresh toggle
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            refresh_done <= 1'h1;
            @(posedge clk);
            refresh_done <= 1'h0;
            rd(tim_a, 16'h4000, (i == 0) ? 16'h4000 : 16'h0000);
        end
        // Frozen while ce is low: the refresh pulse is lost
        ce <= 1'h0;
        refresh_done <= 1'h1;
        @(posedge clk);
        {ce, refresh_done} <= 2'h2;
        rd(tim_a, 16'h4000, 16'h0000);
        // Square wave flips on rising reference edges only
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            standby_refresh_reference <= (i != 1);
            repeat (5) @(posedge clk);
            rd(tim_a, 16'h8000, (i == 2) ? 16'h0000 : 16'h8000);
        end
        // DMA drops the idle bit until a quiet period passes
        @(posedge clk);
        dma_cycle <= 1'h1;
        @(posedge clk);
        dma_cycle <= 1'h0;
        rd(tim_a, 16'h1000, 16'h0000);
        repeat (IDLE_CYCLES + 2) @(posedge clk);
        rd(tim_a, 16'h1000, 16'h1000);
        stop_test();
    end
endmodule : pm_status_shadow_registers_test

// Attach the checker to the register bank
bind pm_status_shadow_registers pm_status_shadow_registers_checker #(
    .DEVICE_ID(DEVICE_ID)
) pm_status_shadow_registers_checker_i (
    .*
);
